// >>> logic/lws_pkg.sv
/*
  lws_pkg: constants, register map and carrier types of the list waveform sequencer.
  Assumes a 25 MHz system clock and an APB master with 32-bit data.
*/
package lws_pkg;
  localparam int DEPTH = 1002;
  localparam int IDX_W = 10;
  localparam int VAL_W = 16;
  localparam int WIN = 16;
  // times
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 500000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [VAL_W-1:0] DWELL_MIN = 16'h0001;
  localparam logic [VAL_W-1:0] DWELL_MAX = 16'h4e20;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_SKIP = 8'h0c;
  localparam logic [7:0] OFS_QSTART = 8'h10;
  localparam logic [7:0] OFS_CURR_APPEND = 8'h14;
  localparam logic [7:0] OFS_VOLT_APPEND = 8'h18;
  localparam logic [7:0] OFS_DWELL_APPEND = 8'h1c;
  localparam logic [7:0] OFS_CURR_POINTS = 8'h20;
  localparam logic [7:0] OFS_VOLT_POINTS = 8'h24;
  localparam logic [7:0] OFS_DWELL_POINTS = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_ERROR = 8'h30;
  localparam logic [7:0] OFS_MAIN_WIN = 8'h40;
  localparam logic [7:0] OFS_DWELL_WIN = 8'h80;
  // field positions
  localparam int CTRL_CLEAR = 0;
  localparam int CTRL_CURR_RUN = 1;
  localparam int CTRL_VOLT_RUN = 2;
  localparam int CTRL_HALT = 3;
  localparam int MODE_CURR = 0;
  localparam int MODE_DOWN = 1;
  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h01;
  localparam logic [7:0] SKIP_RESET = 8'h00;
  // error codes
  localparam logic [31:0] ERR_NONE = 32'h00000000;
  localparam logic [31:0] ERR_CONFLICT = 32'hffffff23;
  localparam logic [31:0] ERR_RANGE = 32'hffffff22;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } lws_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } lws_apb_rsp_s;

  typedef struct packed {
    logic active;
    logic modeCurr;
    logic [VAL_W-1:0] value;
    logic [IDX_W-1:0] step;
  } lws_out_s;
endpackage : lws_pkg

// >>> logic/lws_sequencer.sv
/*
  lws_sequencer: list waveform sequencer with APB register access, data and dwell
  tables in flip-flops, and a dwell timer ticking every 0.5 ms.
  Assumes APB inputs synchronous to clk_sys and a synchronous active-high reset.
*/
// The register offsets and register access over APB were decided locally.
// Notes on behaviour
// - current appends fill next free main location, at most 1002 entries.
// - voltage entries present: current append, readback, point count post -221.
// - clear zeroes all fill pointers; each append advances its pointer by one.
// - current point count returns the next location to be written.
// - main readback gives up to 16 values from the query-start pointer.
// - operating mode decides whether main table holds voltage or current.
// - direction selects up or down; reset and clear force up.
// - direction can be read back as up or down.
// - dwell values 0.5 ms to 10 s append sequentially, up to 1002.
// - each dwell location times the main value at the same index.
// - only dwell location 0 written: it times every step.
// - dwell readback gives up to 16 dwell times from query-start pointer.
// - dwell point count returns number of written dwell locations.
// - main locations map straight onto the default execution order.
// - voltage list run starts stepping, holding each value for its dwell.
// - after the last step the list jumps straight to the first step of the next pass.
// - after all repetitions execution stops holding the last value.
// - going down the last executed step is location 0 and holds.
// - first pass runs all steps, later passes omit leading skip steps.
// - repeat count 0 to 255 sets how many passes run.
// - repeat count 0 runs forever until halted.
// - skipping only applies going up.
`timescale 1ns/1ps
module lws_sequencer #(
  parameter int TICK_CYC = lws_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lws_pkg::lws_apb_req_s apbReq,
  output lws_pkg::lws_apb_rsp_s apbRsp,
  output lws_pkg::lws_out_s seqOut
);
  import lws_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][VAL_W-1:0] mainTab;
    logic [DEPTH-1:0][VAL_W-1:0] dwellTab;
    logic [IDX_W-1:0] currPtr;
    logic [IDX_W-1:0] voltPtr;
    logic [IDX_W-1:0] dwellPtr;
    logic [IDX_W-1:0] queryPtr;
    logic modeCurr;
    logic dirDown;
    logic [7:0] repCount;
    logic [7:0] skipCount;
    logic running;
    logic [IDX_W-1:0] stepIdx;
    logic [IDX_W-1:0] runLen;
    logic [7:0] repDone;
    logic [15:0] tickDiv;
    logic [VAL_W-1:0] dwellCnt;
    logic [VAL_W-1:0] outValue;
    logic [31:0] errCode;
    logic [31:0] prdata;
    logic pslverr;
  } lws_state_s;

  lws_state_s st;
  lws_state_s next_st;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [IDX_W-1:0] DEPTH_IDX = IDX_W'(DEPTH);
  localparam logic [IDX_W-1:0] ONE_IDX = 10'h001;

  logic setupRd;
  logic accessWr;
  logic accessRd;
  logic [IDX_W-1:0] winIdx;
  logic [IDX_W-1:0] mainFill;
  logic [31:0] rdData;
  logic rdErr;
  logic [VAL_W-1:0] dwellNow;
  logic [IDX_W-1:0] wrapIdx;
  logic [IDX_W-1:0] nextIdx;
  logic lastStep;
  logic [IDX_W-1:0] startLen;
  logic [IDX_W-1:0] startIdx;

  assign setupRd = apbReq.psel & ~apbReq.penable;
  assign accessWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign accessRd = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  assign winIdx = st.queryPtr + IDX_W'(apbReq.paddr[5:2]);
  assign mainFill = st.modeCurr ? st.currPtr : st.voltPtr;

  // read mux, sampled into prdata during the setup cycle
  always_comb begin
    rdData = 32'h00000000;
    rdErr = 1'b0;
    if (apbReq.paddr[7:6] == OFS_MAIN_WIN[7:6]) begin
      if (winIdx < mainFill) begin
        rdData = 32'(st.mainTab[winIdx]);
      end
    end else if (apbReq.paddr[7:6] == OFS_DWELL_WIN[7:6]) begin
      if (winIdx < st.dwellPtr) begin
        rdData = 32'(st.dwellTab[winIdx]);
      end
    end else begin
      unique case (apbReq.paddr)
        OFS_CTRL: rdData = 32'h00000000;
        OFS_MODE: rdData = 32'({st.dirDown, st.modeCurr});
        OFS_COUNT: rdData = 32'(st.repCount);
        OFS_SKIP: rdData = 32'(st.skipCount);
        OFS_QSTART: rdData = 32'(st.queryPtr);
        OFS_CURR_APPEND: rdData = 32'h00000000;
        OFS_VOLT_APPEND: rdData = 32'h00000000;
        OFS_DWELL_APPEND: rdData = 32'h00000000;
        OFS_CURR_POINTS: rdData = 32'(st.currPtr);
        OFS_VOLT_POINTS: rdData = 32'(st.voltPtr);
        OFS_DWELL_POINTS: rdData = 32'(st.dwellPtr);
        OFS_STATUS: rdData = {st.repDone, 5'h00, st.runLen, st.stepIdx[7:0], st.running};
        OFS_ERROR: rdData = st.errCode;
        default: rdErr = 1'b1;
      endcase
    end
  end

  // sequencer helpers
  always_comb begin
    // a lone dwell entry times every step
    dwellNow = st.dwellTab[0];
    if (st.dwellPtr != ONE_IDX && st.stepIdx < DEPTH_IDX) begin
      dwellNow = st.dwellTab[st.stepIdx];
    end
    lastStep = st.dirDown ? (st.stepIdx == '0) : (st.stepIdx == st.runLen - ONE_IDX);
    // skip beyond the list length would leave nothing to run, so it is ignored
    if (st.dirDown) begin
      wrapIdx = st.runLen - ONE_IDX;
    end else if (IDX_W'(st.skipCount) < st.runLen) begin
      wrapIdx = IDX_W'(st.skipCount);
    end else begin
      wrapIdx = '0;
    end
    nextIdx = st.dirDown ? st.stepIdx - ONE_IDX : st.stepIdx + ONE_IDX;
    startLen = mainFill;
    startIdx = st.dirDown ? mainFill - ONE_IDX : '0;
  end

  always_comb begin
    next_st = st;
    // dwell timer and stepping
    if (st.running) begin
      if (st.tickDiv == TICK_LAST) begin
        next_st.tickDiv = '0;
        if (st.dwellCnt + 16'h0001 >= dwellNow) begin
          next_st.dwellCnt = '0;
          if (lastStep) begin
            if (st.repCount != 8'h00 && st.repDone + 8'h01 == st.repCount) begin
              next_st.running = 1'b0;
            end else begin
              if (st.repCount != 8'h00) begin
                next_st.repDone = st.repDone + 8'h01;
              end
              next_st.stepIdx = wrapIdx;
              next_st.outValue = st.mainTab[wrapIdx];
            end
          end else begin
            next_st.stepIdx = nextIdx;
            next_st.outValue = st.mainTab[nextIdx];
          end
        end else begin
          next_st.dwellCnt = st.dwellCnt + 16'h0001;
        end
      end else begin
        next_st.tickDiv = st.tickDiv + 16'h0001;
      end
    end

    // apb read: answer captured at setup, error side effects at access
    if (setupRd) begin
      next_st.prdata = rdData;
      next_st.pslverr = rdErr;
    end else if (apbReq.psel & apbReq.pwrite & ~apbReq.penable) begin
      next_st.prdata = 32'h00000000;
      next_st.pslverr = rdErr;
    end
    if (accessRd) begin
      if (apbReq.paddr == OFS_ERROR) begin
        next_st.errCode = ERR_NONE;
      end
      if (st.voltPtr != '0 && (apbReq.paddr == OFS_CURR_POINTS
          || (apbReq.paddr[7:6] == OFS_MAIN_WIN[7:6] && st.modeCurr))) begin
        next_st.errCode = ERR_CONFLICT;
      end
    end

    // apb writes
    if (accessWr && !rdErr) begin
      if (st.running && !(apbReq.paddr == OFS_CTRL && apbReq.pwdata[CTRL_HALT])) begin
        next_st.errCode = ERR_CONFLICT;
      end else begin
        unique case (apbReq.paddr)
          OFS_CTRL: begin
            if (apbReq.pwdata[CTRL_HALT]) begin
              next_st.running = 1'b0;
              // a tick landing on the halt edge must not move the held output
              next_st.stepIdx = st.stepIdx;
              next_st.outValue = st.outValue;
            end else if (apbReq.pwdata[CTRL_CLEAR]) begin
              next_st.currPtr = '0;
              next_st.voltPtr = '0;
              next_st.dwellPtr = '0;
              next_st.queryPtr = '0;
              next_st.dirDown = 1'b0;
              next_st.repCount = COUNT_RESET;
              next_st.skipCount = SKIP_RESET;
            end else if (apbReq.pwdata[CTRL_CURR_RUN] | apbReq.pwdata[CTRL_VOLT_RUN]) begin
              // run needs a matching mode, data, and balanced dwell entries
              if (apbReq.pwdata[CTRL_CURR_RUN] != st.modeCurr || startLen == '0
                  || !(st.dwellPtr == ONE_IDX || st.dwellPtr == startLen)) begin
                next_st.errCode = ERR_CONFLICT;
              end else begin
                next_st.running = 1'b1;
                next_st.runLen = startLen;
                next_st.stepIdx = startIdx;
                next_st.outValue = st.mainTab[startIdx];
                next_st.repDone = 8'h00;
                next_st.tickDiv = '0;
                next_st.dwellCnt = '0;
              end
            end
          end
          OFS_MODE: begin
            next_st.modeCurr = apbReq.pwdata[MODE_CURR];
            next_st.dirDown = apbReq.pwdata[MODE_DOWN];
          end
          OFS_COUNT: next_st.repCount = apbReq.pwdata[7:0];
          OFS_SKIP: next_st.skipCount = apbReq.pwdata[7:0];
          OFS_QSTART: begin
            if (apbReq.pwdata[IDX_W-1:0] < DEPTH_IDX) begin
              next_st.queryPtr = apbReq.pwdata[IDX_W-1:0];
            end else begin
              next_st.errCode = ERR_RANGE;
            end
          end
          OFS_CURR_APPEND: begin
            if (st.voltPtr != '0 || !st.modeCurr) begin
              next_st.errCode = ERR_CONFLICT;
            end else if (st.currPtr < DEPTH_IDX) begin
              next_st.mainTab[st.currPtr] = apbReq.pwdata[VAL_W-1:0];
              next_st.currPtr = st.currPtr + ONE_IDX;
            end else begin
              next_st.errCode = ERR_RANGE;
            end
          end
          OFS_VOLT_APPEND: begin
            if (st.currPtr != '0 || st.modeCurr) begin
              next_st.errCode = ERR_CONFLICT;
            end else if (st.voltPtr < DEPTH_IDX) begin
              next_st.mainTab[st.voltPtr] = apbReq.pwdata[VAL_W-1:0];
              next_st.voltPtr = st.voltPtr + ONE_IDX;
            end else begin
              next_st.errCode = ERR_RANGE;
            end
          end
          OFS_DWELL_APPEND: begin
            if (apbReq.pwdata[VAL_W-1:0] < DWELL_MIN || apbReq.pwdata[VAL_W-1:0] > DWELL_MAX
                || apbReq.pwdata[31:VAL_W] != '0 || st.dwellPtr >= DEPTH_IDX) begin
              next_st.errCode = ERR_RANGE;
            end else begin
              next_st.dwellTab[st.dwellPtr] = apbReq.pwdata[VAL_W-1:0];
              next_st.dwellPtr = st.dwellPtr + ONE_IDX;
            end
          end
          default: next_st.errCode = st.errCode;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
      st.repCount <= COUNT_RESET;
      st.skipCount <= SKIP_RESET;
      st.dirDown <= 1'b0;
      st.errCode <= ERR_NONE;
    end else begin
      st <= next_st;
    end
  end

  // single-cycle access phase; data and error come from flops
  assign apbRsp.pready = apbReq.psel & apbReq.penable;
  assign apbRsp.prdata = st.prdata;
  assign apbRsp.pslverr = st.pslverr & apbReq.psel & apbReq.penable;
  assign seqOut.active = st.running;
  assign seqOut.modeCurr = st.modeCurr;
  assign seqOut.value = st.outValue;
  assign seqOut.step = st.stepIdx;
endmodule : lws_sequencer

// >>> sim/lws_sequencer_checker.sv
/*
  lws_sequencer_checker: concurrent checks on the ports of lws_sequencer.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module lws_sequencer_checker #(
  parameter int TICK_CYC = lws_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lws_pkg::lws_apb_req_s apbReq,
  input wire lws_pkg::lws_apb_rsp_s apbRsp,
  input wire lws_pkg::lws_out_s seqOut
);
  import lws_pkg::*;
  logic acc;
  logic [31:0] held;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign acc = apbReq.psel && apbReq.penable && apbReq.pwrite;
  // cycles the present step has stood; lower bound only, dwell may be long
  always_ff @(posedge clk_sys) begin
    held <= (rst || !seqOut.active || $changed(seqOut.step)) ? '0 : held + 1;
  end
  rdy_zero_wait_a: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
    else $error("pready missing in access cycle");
  bad_addr_err_a: assert property (apbReq.psel && apbReq.penable && apbReq.paddr == 8'h34
    |-> apbRsp.pslverr) else $error("no pslverr on unmapped address");
  reset_idle_a: assert property ($fell(rst) |-> !seqOut.active && seqOut.value == '0)
    else $error("outputs not idle after reset");
  halt_stops_a: assert property (acc && apbReq.paddr == OFS_CTRL && apbReq.pwdata[CTRL_HALT]
    |=> !seqOut.active) else $error("halt did not stop the list");
  mode_locked_a: assert property (acc && apbReq.paddr == OFS_MODE && seqOut.active
    |=> $stable(seqOut.modeCurr)) else $error("mode changed while running");
  mode_set_a: assert property (acc && apbReq.paddr == OFS_MODE && !seqOut.active
    |=> seqOut.modeCurr == $past(apbReq.pwdata[MODE_CURR])) else $error("mode not taken");
  stop_holds_a: assert property ($fell(seqOut.active) |-> $stable(seqOut.value))
    else $error("output moved at stop");
  dwell_floor_a: assert property (seqOut.active && $past(seqOut.active)
    && $changed(seqOut.step) |-> held >= TICK_CYC - 1) else $error("step left too early");
endmodule : lws_sequencer_checker

bind lws_sequencer lws_sequencer_checker #(.TICK_CYC(TICK_CYC)) checker_i (.clk_sys(clk_sys),
  .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .seqOut(seqOut));

// >>> sim/lws_host.sv
/*
  lws_host: APB master standing for the host computer.
  Assumes the slave answers with pready; only the bench watchdog ends a wait.
*/
`timescale 1ns/1ps
module lws_host (
  input wire logic clk_sys,
  output lws_pkg::lws_apb_req_s apbReq,
  input wire lws_pkg::lws_apb_rsp_s apbRsp
);
  import lws_pkg::*;
  initial apbReq = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rdata, output logic err);
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    err = apbRsp.pslverr;
    // released bus shows inverted values, never the stale ones
    apbReq <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask : xfer
endmodule : lws_host

// >>> sim/tb.sv
/*
  tb: self-checking bench for lws_sequencer, short tick for fast runs.
  Assumes lws_host as bus master and the checker bound in.
*/
`timescale 1ns/1ps
module tb;
  import lws_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  lws_apb_req_s apbReq;
  lws_apb_rsp_s apbRsp;
  lws_out_s seqOut;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h4752fe79;
  logic [31:0] r;
  logic e;
  logic [15:0] tbl [5];
  logic [9:0] seen [$];
  logic [15:0] vals [$];
  logic [9:0] lastStep = '0;
  logic wasAct = 1'b0;
  always #20 clk_sys = ~clk_sys;
  lws_sequencer #(.TICK_CYC(4)) lws_sequencer_i (.clk_sys(clk_sys), .rst(rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .seqOut(seqOut));
  lws_host lws_host_i (.clk_sys(clk_sys), .apbReq(apbReq), .apbRsp(apbRsp));
  always @(posedge clk_sys) begin
    if (seqOut.active === 1'b1 && (!wasAct || seqOut.step !== lastStep)) begin
      seen.push_back(seqOut.step);
      vals.push_back(seqOut.value);
    end
    lastStep <= seqOut.step;
    wasAct <= seqOut.active === 1'b1;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : nxt
  // location visited at position i of one full pass
  function automatic int exp_step(input int i, input int n, input logic down);
    return down ? n - 1 - i : i;
  endfunction : exp_step
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    lws_host_i.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    lws_host_i.xfer(1'b0, a, '0, r, e);
  endtask : rd
  // start a run with control word go and compare every step taken with the expected order
  task automatic run(input int n, input int cnt, input int skip, input logic down,
    input logic [31:0] go);
    int k;
    int s;
    seen.delete();
    vals.delete();
    wr(OFS_CTRL, go);
    repeat (3) @(negedge clk_sys);
    k = 0;
    while (seqOut.active === 1'b1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    k = 0;
    for (int p = 0; p < cnt; p++) begin
      for (int i = (p > 0 && !down) ? skip : 0; i < n; i++) begin
        s = exp_step(i, n, down);
        chk("step", 32'(seen[k]), s);
        chk("value", 32'(vals[k]), 32'(tbl[s]));
        k++;
      end
    end
    chk("steps", seen.size(), k);
    chk("hold", 32'(seqOut.value), 32'(tbl[down ? 0 : n - 1]));
  endtask : run
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_COUNT);
    chk("count reset", r, 32'(COUNT_RESET));
    rd(OFS_MODE);
    chk("mode reset", r, 32'h0);
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      seed = nxt(seed);
      tbl[i] = seed[15:0];
      wr(OFS_VOLT_APPEND, {16'h0, tbl[i]});
    end
    rd(OFS_VOLT_POINTS);
    chk("volt points", r, 32'h5);
    wr(OFS_DWELL_APPEND, 32'h1);
    rd(OFS_DWELL_POINTS);
    chk("dwell points", r, 32'h1);
    rd(OFS_DWELL_WIN);
    chk("dwell window", r, 32'h1);
    wr(OFS_DWELL_APPEND, 32'h0);
    rd(OFS_ERROR);
    chk("dwell range", r, ERR_RANGE);
    for (int i = 0; i < 6; i++) begin
      rd(OFS_MAIN_WIN + 8'(4 * i));
      chk("window", r, (i < 5) ? 32'(tbl[i]) : 32'h0);
    end
    wr(OFS_COUNT, 32'h2);
    wr(OFS_SKIP, 32'h1);
    run(5, 2, 1, 1'b0, 32'h4);
    wr(OFS_MODE, 32'h2);
    rd(OFS_MODE);
    chk("direction", r, 32'h2);
    run(5, 2, 1, 1'b1, 32'h4);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_MODE, 32'h0);
    wr(OFS_VOLT_APPEND, 32'h7);
    rd(OFS_ERROR);
    chk("busy error", r, ERR_CONFLICT);
    rd(OFS_VOLT_POINTS);
    chk("points kept", r, 32'h5);
    repeat (100) @(negedge clk_sys);
    chk("endless", 32'(seqOut.active), 32'h1);
    wr(OFS_CTRL, 32'h8);
    @(negedge clk_sys);
    chk("halted", 32'(seqOut.active), 32'h0);
    wr(OFS_MODE, 32'h3);
    wr(OFS_CURR_APPEND, 32'h3);
    rd(OFS_ERROR);
    chk("conflict", r, ERR_CONFLICT);
    rd(OFS_CURR_POINTS);
    rd(OFS_ERROR);
    chk("points conflict", r, ERR_CONFLICT);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_MODE);
    chk("clear dir", r, 32'h1);
    for (int i = 0; i < 2; i++) begin
      seed = nxt(seed);
      tbl[i] = seed[15:0];
      wr(OFS_CURR_APPEND, {16'h0, tbl[i]});
    end
    rd(OFS_CURR_POINTS);
    chk("curr points", r, 32'h2);
    wr(OFS_DWELL_APPEND, 32'h1);
    run(2, 1, 0, 1'b0, 32'h2);
    lws_host_i.xfer(1'b0, 8'h34, '0, r, e);
    chk("unmapped", 32'(e), 32'h1);
    test_done();
  end
endmodule : tb
